/* File: common/lcd_cfg.svh */
// Timing counts and code limits for the LED current step controller.
// Assumes a 25 MHz core clock; included by the package users.
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH
`define LCD_CLK_HZ          25000000
`define LCD_CODE_W          5
`define LCD_CODE_MAX        5'h1f
`define LCD_CODE_HI         5'h08
`define LCD_SLEEP_US        100
`define LCD_SLEEP_CYC       ((`LCD_SLEEP_US * (`LCD_CLK_HZ / 1000000)) + 1)
`define LCD_SETTLE_US       50
`define LCD_SETTLE_CYC      (`LCD_SETTLE_US * (`LCD_CLK_HZ / 1000000))
`define LCD_TIMEOUT_S       4
`define LCD_TIMEOUT_CYC     (`LCD_TIMEOUT_S * `LCD_CLK_HZ)
`define LCD_POR_MS          20
`define LCD_POR_CYC         (`LCD_POR_MS * (`LCD_CLK_HZ / 1000))
`endif

/* File: common/lcd_pkg.sv */
// Types for the LED current step controller.
// Assumes lcd_cfg.svh supplies all numeric constants.
package lcd_pkg;
    typedef enum logic [1:0] {
        LCD_POR,
        LCD_OFF,
        LCD_ON,
        LCD_SLEEP
    } lcd_state_t;
endpackage

/* File: design/lcd_sync.sv */
// Two flip-flop synchroniser for one asynchronous pin.
// Assumes a single clock with synchronous active-high reset.
`timescale 1ns/100ps
module lcd_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

/* File: design/lcd_ctrl.sv */
// Step-programmed LED current code, sleep, timeout and thermal gating.
// Assumes EN and CTRL are asynchronous pins; thermal trip is a level.
`timescale 1ns/100ps
`include "lcd_cfg.svh"

// Behaviour
// R01 - Enable high drives; low disables, clears code
// R02 - Each step rising edge adds one unit
// R03 - Code is unsigned five bits, zero initially
// R04 - At 31 further edges are ignored
// R05 - Step low past 100us enters sleep
// R06 - Host cycles enable to lower current
// R07 - Code above 8 on 4s forces sleep
// R08 - Enable cycling restarts the timeout
// R09 - Edges in sleep wake and add steps
// R10 - Host keeps step rate at most 4MHz
// R11 - Output settles within 50us of last step
// R12 - Either step level at power-up, rising only
// R13 - Thermal trip gates output, keeps code
// R14 - Power-on reset clears code and timeout
// R15 - Step activity ignored during power-on reset
// R16 - Host always drives both inputs
// R17 - Power-on reset lasts at most 20ms
// R18 - Low-time counter restarts falling, clears rising
module lcd_ctrl
    import lcd_pkg::*;
#(
    parameter int TIMEOUT_CYC = `LCD_TIMEOUT_CYC,
    parameter int POR_CYC     = `LCD_POR_CYC,
    parameter int SLEEP_CYC   = `LCD_SLEEP_CYC
) (
    input  wire logic       CORE_CLK,
    input  wire logic       SYS_RST,
    input  wire logic       DRV_EN,
    input  wire logic       STEP_IN,
    input  wire logic       THERM_TRIP,
    output logic [4:0]      CUR_CODE,
    output logic            DRV_ON,
    output logic            SLEEP,
    output logic            SETTLED,
    output logic            POR_BUSY
);
    localparam int SETTLE_CYC = `LCD_SETTLE_CYC;

    if (TIMEOUT_CYC < 2 || POR_CYC < 1 || SLEEP_CYC < 2) begin : g_bad_cnt
        $error("lcd_ctrl: count parameters too small");
    end

    logic             en_s;
    logic             step_s;
    logic             therm_s;
    logic             step_d_r;
    logic             en_d_r;
    lcd_state_t       state_r;
    lcd_state_t       state_nxt;
    logic [4:0]       code_r;
    logic [31:0]      por_cnt_r;
    logic [31:0]      low_cnt_r;
    logic [31:0]      to_cnt_r;
    logic [31:0]      set_cnt_r;
    logic             armed_r;

    lcd_sync u_en (
        .clk (CORE_CLK),
        .rst (SYS_RST),
        .d   (DRV_EN),
        .q   (en_s)
    );
    lcd_sync u_step (
        .clk (CORE_CLK),
        .rst (SYS_RST),
        .d   (STEP_IN),
        .q   (step_s)
    );
    lcd_sync u_therm (
        .clk (CORE_CLK),
        .rst (SYS_RST),
        .d   (THERM_TRIP),
        .q   (therm_s)
    );

    wire in_por    = (state_r == LCD_POR);
    wire step_rise = step_s & ~step_d_r & ~in_por;              // [R12] [R15]
    wire step_fall = ~step_s & step_d_r;
    wire en_rise   = en_s & ~en_d_r;
    wire code_full = (code_r == `LCD_CODE_MAX);
    wire code_hi   = (code_r > `LCD_CODE_HI);
    wire low_done  = armed_r && (low_cnt_r == 32'(SLEEP_CYC - 1));
    wire to_done   = (state_r == LCD_ON) && code_hi
                     && (to_cnt_r == 32'(TIMEOUT_CYC - 1));
    wire por_done  = (por_cnt_r == 32'(POR_CYC - 1));
    wire do_inc    = step_rise && en_s && !code_full;           // [R02] [R04]
    wire drive_nxt = (state_nxt == LCD_ON) && !therm_s;         // [R13]

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            LCD_POR: begin
                if (por_done)                                   // [R17]
                    state_nxt = en_s ? LCD_ON : LCD_OFF;
            end
            LCD_OFF: begin
                if (en_s)
                    state_nxt = LCD_ON;                         // [R01]
            end
            LCD_ON: begin
                if (!en_s)
                    state_nxt = LCD_OFF;                        // [R01]
                else if (low_done || to_done)
                    state_nxt = LCD_SLEEP;                      // [R05] [R07]
            end
            LCD_SLEEP: begin
                if (!en_s)
                    state_nxt = LCD_OFF;
                else if (step_rise)
                    state_nxt = LCD_ON;                         // [R09]
            end
            default: state_nxt = LCD_POR;
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_r  <= LCD_POR;
            step_d_r <= 1'b0;
            en_d_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            step_d_r <= step_s;
            en_d_r   <= en_s;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST)
            por_cnt_r <= 32'h0;                                 // [R14]
        else if (in_por && !por_done)
            por_cnt_r <= por_cnt_r + 32'h1;
    end

    // Code counter, cleared by enable low and during power-on
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || in_por || !en_s)
            code_r <= 5'h00;                                    // [R01] [R14]
        else if (do_inc)
            code_r <= code_r + 5'h01;                           // [R02] [R03]
    end

    // Low-time counter restarts at falling edge, clears at rising
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || step_rise) begin
            low_cnt_r <= 32'h0;                                 // [R18]
            armed_r   <= 1'b0;
        end else if (step_fall && !in_por) begin
            low_cnt_r <= 32'h0;                                 // [R18]
            armed_r   <= 1'b1;
        end else if (armed_r && !low_done) begin
            low_cnt_r <= low_cnt_r + 32'h1;                     // [R05]
        end else if (low_done) begin
            armed_r   <= 1'b0;
        end
    end

    // Timeout runs only in the on state above the high-current code
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || in_por || !en_s || en_rise)
            to_cnt_r <= 32'h0;                                  // [R08] [R14]
        else if (state_r == LCD_ON && code_hi && !to_done)
            to_cnt_r <= to_cnt_r + 32'h1;                       // [R07]
        else if (state_r != LCD_ON)
            to_cnt_r <= 32'h0;
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST || step_rise)
            set_cnt_r <= 32'h0;
        else if (set_cnt_r != 32'(SETTLE_CYC))
            set_cnt_r <= set_cnt_r + 32'h1;                     // [R11]
    end

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CUR_CODE <= 5'h00;
            DRV_ON   <= 1'b0;
            SLEEP    <= 1'b0;
            SETTLED  <= 1'b0;
            POR_BUSY <= 1'b1;
        end else begin
            CUR_CODE <= code_r;
            DRV_ON   <= drive_nxt;                              // [R13]
            SLEEP    <= (state_nxt == LCD_SLEEP);
            SETTLED  <= (set_cnt_r == 32'(SETTLE_CYC));         // [R11]
            POR_BUSY <= (state_nxt == LCD_POR);
        end
    end

    property p_code_clear;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        !en_s |=> code_r == 5'h00;
    endproperty
    a_code_clear: assert property (p_code_clear)                // [R01]
        else $error("code not cleared while disabled");

    property p_step_inc;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (step_rise && en_s && !code_full && !in_por && $past(en_s))
        |=> code_r == $past(code_r) + 5'h01;
    endproperty
    a_step_inc: assert property (p_step_inc)                    // [R02]
        else $error("step edge did not add one");

    property p_saturate;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (code_full && en_s) |=> (code_r == `LCD_CODE_MAX) || !$past(en_s);
    endproperty
    a_saturate: assert property (p_saturate)                    // [R04]
        else $error("code left full scale");

    property p_no_inc_idle;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (!step_rise && en_s && !in_por) |=> code_r == $past(code_r);
    endproperty
    a_no_inc_idle: assert property (p_no_inc_idle)              // [R12]
        else $error("code moved without rising edge");

    property p_por_ignore;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        in_por |=> code_r == 5'h00 && CUR_CODE == 5'h00;
    endproperty
    a_por_ignore: assert property (p_por_ignore)                // [R15]
        else $error("code changed during power-on reset");

    property p_therm_gate;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        therm_s |=> !DRV_ON;
    endproperty
    a_therm_gate: assert property (p_therm_gate)                // [R13]
        else $error("driver on during thermal trip");

    property p_sleep_entry;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (state_r == LCD_ON && en_s && low_done) |=> state_r == LCD_SLEEP;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)              // [R05]
        else $error("no sleep after long step low");

    property p_timeout;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (to_done && en_s) |=> state_r == LCD_SLEEP && !DRV_ON;
    endproperty
    a_timeout: assert property (p_timeout)                      // [R07]
        else $error("timeout did not force sleep");

    property p_wake;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        (state_r == LCD_SLEEP && en_s && step_rise) |=> state_r == LCD_ON;
    endproperty
    a_wake: assert property (p_wake)                            // [R09]
        else $error("step edge did not wake from sleep");

    property p_restart;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        en_rise |=> to_cnt_r == 32'h0;
    endproperty
    a_restart: assert property (p_restart)                      // [R08]
        else $error("enable cycle did not restart timeout");

    property p_por_len;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        por_done && in_por |=> !in_por;
    endproperty
    a_por_len: assert property (p_por_len)                      // [R17]
        else $error("power-on reset overran");

    property p_low_clear;
        @(posedge CORE_CLK) disable iff (SYS_RST)
        step_rise |=> low_cnt_r == 32'h0 && !armed_r;
    endproperty
    a_low_clear: assert property (p_low_clear)                  // [R18]
        else $error("low counter not cleared on rising edge");
endmodule

/* File: dv/lcd_host.sv */
// Host model that drives the enable and step pins of the controller.
// Assumes the bench calls its tasks; pins change on falling clock edges.
`timescale 1ns/100ps
module lcd_host (
    input  wire logic clk,
    output logic      drv_en,
    output logic      step_in
);
    // Both pins driven from time zero
    initial begin
        drv_en  = 1'b1;
        step_in = 1'b0;
    end
    // Levels held 4 cycles each, well under the rate limit
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            step_in = 1'b0;
            repeat (4) @(negedge clk);
            step_in = 1'b1;
            repeat (3) @(negedge clk);
        end
    endtask
    task automatic en_set(input logic v);
        @(negedge clk);
        drv_en = v;
    endtask
    task automatic idle_low();
        @(negedge clk);
        step_in = 1'b0;
    endtask
endmodule

/* File: dv/lcd_ctrl_tb.sv */
// Self-checking bench for the LED current step controller.
// Assumes lcd_host drives the pins; short counts set by parameters.
`timescale 1ns/100ps
module lcd_ctrl_tb;
    import lcd_pkg::*;
    // Timeout long enough that the 34-pulse row stays below it
    localparam int TO_CYC = 400;
    localparam int SL_CYC = 20;
    localparam int POR_C  = 10;
    typedef struct { int n; logic [4:0] code; } lcd_row_t;
    lcd_row_t rows [5] = '{'{1, 5'h01}, '{2, 5'h02}, '{8, 5'h08},
                           '{31, 5'h1f}, '{34, 5'h1f}};
    logic       core_clk = 1'b0;
    logic       sys_rst  = 1'b1;
    logic       therm    = 1'b0;
    logic       drv_en;
    logic       step_in;
    logic [4:0] cur_code;
    logic       drv_on;
    logic       sleep;
    logic       settled;
    logic       por_busy;
    int         fails = 0;
    int         check_count = 0;

    always #20 core_clk = ~core_clk;

    lcd_host host (.clk(core_clk), .drv_en(drv_en), .step_in(step_in));
    lcd_ctrl #(.TIMEOUT_CYC(TO_CYC), .POR_CYC(POR_C),
               .SLEEP_CYC(SL_CYC)) DUT (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .DRV_EN(drv_en),
        .STEP_IN(step_in), .THERM_TRIP(therm), .CUR_CODE(cur_code),
        .DRV_ON(drv_on), .SLEEP(sleep), .SETTLED(settled),
        .POR_BUSY(por_busy));

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Counts cycles until the power-on interval ends
    task automatic por_wait(input int exp_n);
        int n;
        n = 0;
        while (por_busy !== 1'b0 && n < 100) begin
            wait_n(1);
            n++;
        end
        chk("por_len", n, exp_n);
    endtask
    // Enable low then high, then a fresh sequence
    task automatic restart(input int n);
        host.en_set(1'b0);
        wait_n(6);
        chk("code_off", cur_code, 0);
        chk("on_off", drv_on, 0);
        host.en_set(1'b1);
        wait_n(6);
        host.pulse(n);
        wait_n(6);
    endtask
    task automatic summarize();
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        summarize();
    end

    initial begin
        wait_n(7);
        chk("por_busy", por_busy, 1);
        chk("code_rst", cur_code, 0);
        sys_rst = 1'b0;
        host.pulse(1);
        // The pulse above used 8 cycles of the interval
        por_wait(POR_C - 8);
        wait_n(6);
        chk("code_por", cur_code, 0);
        foreach (rows[i]) begin
            restart(rows[i].n);
            chk("code", cur_code, rows[i].code);
            chk("on", drv_on, 1);
        end
        therm = 1'b1;
        wait_n(6);
        chk("on_hot", drv_on, 0);
        chk("code_hot", cur_code, 5'h1f);
        therm = 1'b0;
        wait_n(6);
        chk("on_cool", drv_on, 1);
        restart(3);
        host.idle_low();
        wait_n(SL_CYC + 10);
        chk("sleep", sleep, 1);
        chk("on_sleep", drv_on, 0);
        chk("code_sleep", cur_code, 3);
        host.pulse(1);
        wait_n(6);
        chk("code_wake", cur_code, 4);
        chk("on_wake", drv_on, 1);
        chk("sleep_wake", sleep, 0);
        chk("settled_lo", settled, 0);
        wait_n(1260);
        chk("settled_hi", settled, 1);
        restart(8);
        wait_n(TO_CYC + 50);
        chk("sleep_8", sleep, 0);
        restart(9);
        wait_n(300);
        restart(9);
        wait_n(300);
        chk("sleep_cyc", sleep, 0);
        wait_n(120);
        chk("sleep_to", sleep, 1);
        chk("on_to", drv_on, 0);
        chk("code_to", cur_code, 9);
        // Reset in mid-run with the step pin high
        sys_rst = 1'b1;
        wait_n(6);
        chk("code_rst2", cur_code, 0);
        chk("sleep_rst2", sleep, 0);
        chk("por_busy2", por_busy, 1);
        sys_rst = 1'b0;
        por_wait(POR_C);
        wait_n(6);
        chk("code_por2", cur_code, 0);
        chk("on_por2", drv_on, 1);
        host.pulse(1);
        wait_n(6);
        chk("code_hi_start", cur_code, 1);
        summarize();
    end
endmodule
